// >>> lpw_cfg.svh
// Constants for the low-power wake controller: command codes, offsets, field positions, reset values.
// Assumes inclusion by lpw_ctrl, lpw_host and the bench; definitions only.
`ifndef LPW_CFG_SVH
`define LPW_CFG_SVH

// ********************
// Register offsets
// ********************
`define LPW_CTRL_OFF 12'h000
`define LPW_TGT_TIME_OFF 12'h004
`define LPW_TGT_DATE_OFF 12'h008
`define LPW_SECS_OFF 12'h00C
`define LPW_STAT_OFF 12'h010
`define LPW_RTC_TIME_OFF 12'h014
`define LPW_RTC_DATE_OFF 12'h018

// ********************
// Control fields
// ********************
`define LPW_CTRL_GO_BIT 0
`define LPW_CTRL_MODE_LSB 1
`define LPW_CTRL_SER_BIT 3
`define LPW_CTRL_KIND_LSB 4
`define LPW_CTRL_NOARG_BIT 7
`define LPW_CTRL_HASYR_BIT 8
`define LPW_CTRL_ABORT_BIT 9

// ********************
// Mode and target codes
// ********************
`define LPW_MODE_SLEEP 2'h1
`define LPW_MODE_IDLE 2'h2
`define LPW_MODE_DEEP 2'h3
`define LPW_KIND_NONE 3'h0
`define LPW_KIND_SECS 3'h1
`define LPW_KIND_TIME 3'h2
`define LPW_KIND_TOP 3'h3
`define LPW_KIND_DATE 3'h4
`define LPW_KIND_DTTM 3'h5

// ********************
// Wake source codes
// ********************
`define LPW_SRC_NONE 3'h0
`define LPW_SRC_SECS 3'h1
`define LPW_SRC_CLOCK 3'h2
`define LPW_SRC_TRIG 3'h3
`define LPW_SRC_CHAR 3'h4
`define LPW_SRC_ABORT 3'h5

// ********************
// Reset values
// ********************
`define LPW_CTRL_RST 32'h0000_0000
`define LPW_TGT_RST 24'h00_0000
`define LPW_SECS_RST 32'h0000_0000

`endif

// >>> lpw_pkg.sv
// Types for the low-power wake controller.
// Assumes lpw_cfg.svh holds the numeric constants.
`default_nettype none
package lpw_pkg;
    typedef enum logic [1:0] {
        LPW_ACTIVE,
        LPW_LIGHT,
        LPW_DEEP
    } lpw_state_t;
endpackage
`default_nettype wire

// >>> lpw_sync.sv
// Three-stage synchroniser for a pin level; change counts once stages two and three agree.
// Assumes an asynchronous pin and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lpw_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin and clean level
    input wire logic pin_in,
    output logic level_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_ff <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
        end
    end

    assign level_out = lvl_ff;
endmodule
`default_nettype wire

// >>> lpw_match.sv
// Clock and date comparator for the wake target.
// Assumes BCD-free binary fields from the real-time clock, all on pclk.
`timescale 1ns/1ps
`default_nettype none
module lpw_match (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Current clock
    input wire logic [4:0] rtc_hour,
    input wire logic [5:0] rtc_min,
    input wire logic [5:0] rtc_sec,
    input wire logic [3:0] rtc_month,
    input wire logic [4:0] rtc_day,
    input wire logic [6:0] rtc_year,
    // Target
    input wire logic [4:0] tgt_hour,
    input wire logic [5:0] tgt_min,
    input wire logic [5:0] tgt_sec,
    input wire logic [3:0] tgt_month,
    input wire logic [4:0] tgt_day,
    input wire logic [6:0] tgt_year,
    input wire logic use_year,
    // Match flags
    output logic time_hit,
    output logic date_hit,
    output logic top_hit
);
    logic time_ff;
    logic date_ff;
    logic top_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_ff <= 1'b0;
            date_ff <= 1'b0;
            top_ff <= 1'b0;
        end else begin
            time_ff <= (rtc_hour == tgt_hour) && (rtc_min == tgt_min) && (rtc_sec == tgt_sec);
            date_ff <= (rtc_month == tgt_month) && (rtc_day == tgt_day) &&
                       (!use_year || (rtc_year == tgt_year));
            top_ff <= (rtc_min == 6'h00) && (rtc_sec == 6'h00);
        end
    end

    assign time_hit = time_ff;
    assign date_hit = date_ff;
    assign top_hit = top_ff;
endmodule
`default_nettype wire

// >>> lpw_ctrl.sv
// Low-power wake controller: light sleep, idle and deep sleep with their wake sources, on APB.
// Assumes a one-pulse-per-second tick and clock fields on pclk, an asynchronous trigger pin,
// and a receive path that reports a character arrival as a one-cycle pulse.
//
// Contract
// R1: Light sleep and idle switch off only the LEDs.
// R2: Light states end on seconds, clock match, trigger or enabled character.
// R3: Sleep discards the waking character; idle keeps it for next receive.
// R4: Deep sleep disables LEDs, RS232, USB, logic serial and all serial channels.
// R5: Deep sleep ends only on seconds, date/time or trigger, never on character; the code also ends it on an abort write.
// R6: Trigger ends deep sleep at once regardless of target.
// R7: Character wake armed only by flag; plain number is seconds timeout.
// R8: Time argument may be hh:mm:ss or top of next hour.
// R9: No arguments means serial wake on and no timeout.
// R10: Serial plus timeout wakes at whichever comes first.
// R11: Absolute time alone in light sleep disables character wake.
// R12: Hours and minutes only take seconds as zero.
// R13: Top wakes when minutes and seconds reach zero; alone disables character wake.
// R14: Month/day without year wakes at hour zero of that date.
// R15: Two-digit year wakes on that exact date.
// R16: Time with date wakes when both match.
// R17: Plain number in deep sleep counts seconds from entry.
// R18: Any wake returns to active, restores functions, records the source.
`timescale 1ns/1ps
`default_nettype none
`include "lpw_cfg.svh"
module lpw_ctrl
    import lpw_pkg::*;
#(
    parameter int SECS_W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Real-time clock
    input wire logic sec_tick,
    input wire logic [4:0] rtc_hour,
    input wire logic [5:0] rtc_min,
    input wire logic [5:0] rtc_sec,
    input wire logic [3:0] rtc_month,
    input wire logic [4:0] rtc_day,
    input wire logic [6:0] rtc_year,
    // Wake events
    input wire logic ext_trig_pin,
    input wire logic rx_char_pulse,
    // Function enables and receive buffer control
    output logic led_en,
    output logic rs232_en,
    output logic usb_en,
    output logic logic_serial_en,
    output logic other_serial_en,
    output logic rx_char_drop,
    output logic low_power
);
    // ********************
    // Declarations
    // ********************
    lpw_state_t state_ff;
    lpw_state_t nxt_state;
    logic is_idle_ff;
    logic ser_en_ff;
    logic [2:0] kind_ff;
    logic use_year_ff;
    logic [4:0] tgt_hour_ff;
    logic [5:0] tgt_min_ff;
    logic [5:0] tgt_sec_ff;
    logic [3:0] tgt_month_ff;
    logic [4:0] tgt_day_ff;
    logic [6:0] tgt_year_ff;
    logic [SECS_W-1:0] secs_ff;
    logic [SECS_W-1:0] left_ff;
    logic [2:0] src_ff;
    logic [2:0] nxt_src;
    logic wake;
    logic drop_ff;
    logic [31:0] prdata_ff;
    logic trig_lvl;
    logic trig_prev_ff;
    logic trig_rise;
    logic time_hit;
    logic date_hit;
    logic top_hit;
    logic clk_hit;
    logic wr_en;
    logic rd_en;
    logic go_cmd;
    logic abort_cmd;
    logic [1:0] cmd_mode;
    logic [2:0] cmd_kind;

    // ********************
    // APB decode
    // ********************
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pslverr = psel && penable && (paddr > `LPW_RTC_DATE_OFF || paddr[1:0] != 2'h0);
    assign go_cmd = wr_en && (paddr == `LPW_CTRL_OFF) && pwdata[`LPW_CTRL_GO_BIT];
    assign abort_cmd = wr_en && (paddr == `LPW_CTRL_OFF) && pwdata[`LPW_CTRL_ABORT_BIT];
    assign cmd_mode = pwdata[`LPW_CTRL_MODE_LSB +: 2];
    assign cmd_kind = pwdata[`LPW_CTRL_KIND_LSB +: 3];

    // ********************
    // Wake inputs
    // ********************
    lpw_sync lpw_sync_i (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(ext_trig_pin),
        .level_out(trig_lvl)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= trig_lvl;
        end
    end

    assign trig_rise = trig_lvl && !trig_prev_ff;

    lpw_match lpw_match_i (
        .pclk(pclk),
        .presetn(presetn),
        .rtc_hour(rtc_hour),
        .rtc_min(rtc_min),
        .rtc_sec(rtc_sec),
        .rtc_month(rtc_month),
        .rtc_day(rtc_day),
        .rtc_year(rtc_year),
        .tgt_hour(tgt_hour_ff),
        .tgt_min(tgt_min_ff),
        .tgt_sec(tgt_sec_ff),
        .tgt_month(tgt_month_ff),
        .tgt_day(tgt_day_ff),
        .tgt_year(tgt_year_ff),
        .use_year(use_year_ff),
        .time_hit(time_hit),
        .date_hit(date_hit),
        .top_hit(top_hit)
    );

    // ********************
    // Command capture
    // ********************
    // R7 flag and seconds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            is_idle_ff <= 1'b0;
            ser_en_ff <= 1'b0;
            kind_ff <= `LPW_KIND_NONE;
            use_year_ff <= 1'b0;
        end else if (go_cmd && state_ff == LPW_ACTIVE) begin
            is_idle_ff <= (cmd_mode == `LPW_MODE_IDLE);
            use_year_ff <= pwdata[`LPW_CTRL_HASYR_BIT];
            // R9 bare command
            if (pwdata[`LPW_CTRL_NOARG_BIT] && cmd_mode != `LPW_MODE_DEEP) begin
                ser_en_ff <= 1'b1;
                kind_ff <= `LPW_KIND_NONE;
            end else begin
                // R5 no character in deep sleep
                ser_en_ff <= pwdata[`LPW_CTRL_SER_BIT] && (cmd_mode != `LPW_MODE_DEEP);
                kind_ff <= cmd_kind;
            end
        end
    end

    // R12 seconds default zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt_hour_ff <= 5'h00;
            tgt_min_ff <= 6'h00;
            tgt_sec_ff <= 6'h00;
        end else if (wr_en && paddr == `LPW_TGT_TIME_OFF && state_ff == LPW_ACTIVE) begin
            tgt_sec_ff <= pwdata[5:0];
            tgt_min_ff <= pwdata[13:8];
            tgt_hour_ff <= pwdata[20:16];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt_day_ff <= 5'h00;
            tgt_month_ff <= 4'h0;
            tgt_year_ff <= 7'h00;
        end else if (wr_en && paddr == `LPW_TGT_DATE_OFF && state_ff == LPW_ACTIVE) begin
            tgt_day_ff <= pwdata[4:0];
            tgt_month_ff <= pwdata[11:8];
            tgt_year_ff <= pwdata[22:16];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secs_ff <= '0;
        end else if (wr_en && paddr == `LPW_SECS_OFF && state_ff == LPW_ACTIVE) begin
            secs_ff <= pwdata[SECS_W-1:0];
        end
    end

    // ********************
    // Wake detection
    // ********************
    // R17 seconds from entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_ff <= '0;
        end else if (go_cmd && state_ff == LPW_ACTIVE) begin
            left_ff <= secs_ff;
        end else if (state_ff != LPW_ACTIVE && sec_tick && left_ff != '0) begin
            left_ff <= left_ff - 1'b1;
        end
    end

    // R8 R11 R13 R14 R15 R16 clock targets
    always_comb begin
        case (kind_ff)
            `LPW_KIND_TIME: clk_hit = time_hit;
            `LPW_KIND_TOP: clk_hit = top_hit;
            `LPW_KIND_DATE: clk_hit = date_hit && (rtc_hour == 5'h00) && (rtc_min == 6'h00) && (rtc_sec == 6'h00);
            `LPW_KIND_DTTM: clk_hit = date_hit && time_hit;
            default: clk_hit = 1'b0;
        endcase
    end

    // R2 R6 R10 first source wins
    always_comb begin
        nxt_src = `LPW_SRC_NONE;
        if (abort_cmd) begin
            nxt_src = `LPW_SRC_ABORT;
        end else if (trig_rise) begin
            nxt_src = `LPW_SRC_TRIG;
        end else if (state_ff == LPW_LIGHT && ser_en_ff && rx_char_pulse) begin
            nxt_src = `LPW_SRC_CHAR;
        end else if (kind_ff == `LPW_KIND_SECS && sec_tick && left_ff == {{(SECS_W-1){1'b0}}, 1'b1}) begin
            nxt_src = `LPW_SRC_SECS;
        end else if (clk_hit && sec_tick) begin
            nxt_src = `LPW_SRC_CLOCK;
        end
    end

    assign wake = (state_ff != LPW_ACTIVE) && (nxt_src != `LPW_SRC_NONE);

    // ********************
    // State machine
    // ********************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LPW_ACTIVE: begin
                if (go_cmd && (cmd_mode == `LPW_MODE_SLEEP || cmd_mode == `LPW_MODE_IDLE)) begin
                    nxt_state = LPW_LIGHT;
                end else if (go_cmd && cmd_mode == `LPW_MODE_DEEP) begin
                    nxt_state = LPW_DEEP;
                end
            end
            LPW_LIGHT, LPW_DEEP: begin
                // R18 back to active
                if (wake) begin
                    nxt_state = LPW_ACTIVE;
                end
            end
            default: nxt_state = LPW_ACTIVE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= LPW_ACTIVE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // R18 record source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ff <= `LPW_SRC_NONE;
        end else if (wake) begin
            src_ff <= nxt_src;
        end
    end

    // R3 drop only in sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_ff <= 1'b0;
        end else begin
            drop_ff <= wake && (nxt_src == `LPW_SRC_CHAR) && !is_idle_ff;
        end
    end

    // ********************
    // Function enables
    // ********************
    // R1 R4 gating
    assign led_en = (state_ff == LPW_ACTIVE);
    assign rs232_en = (state_ff != LPW_DEEP);
    assign usb_en = (state_ff != LPW_DEEP);
    assign logic_serial_en = (state_ff != LPW_DEEP);
    assign other_serial_en = (state_ff != LPW_DEEP);
    assign rx_char_drop = drop_ff;
    assign low_power = (state_ff != LPW_ACTIVE);

    // ********************
    // Read data
    // ********************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `LPW_CTRL_OFF: prdata_ff <= {23'h00_0000, use_year_ff, 1'b0, kind_ff, ser_en_ff, 1'b0, is_idle_ff, 1'b0};
                `LPW_TGT_TIME_OFF: prdata_ff <= {11'h000, tgt_hour_ff, 2'h0, tgt_min_ff, 2'h0, tgt_sec_ff};
                `LPW_TGT_DATE_OFF: prdata_ff <= {9'h000, tgt_year_ff, 4'h0, tgt_month_ff, 3'h0, tgt_day_ff};
                `LPW_SECS_OFF: prdata_ff <= 32'(secs_ff);
                `LPW_STAT_OFF: prdata_ff <= {24'h00_0000, 3'h0, src_ff, state_ff};
                `LPW_RTC_TIME_OFF: prdata_ff <= {11'h000, rtc_hour, 2'h0, rtc_min, 2'h0, rtc_sec};
                `LPW_RTC_DATE_OFF: prdata_ff <= {9'h000, rtc_year, 4'h0, rtc_month, 3'h0, rtc_day};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_ff;

    // ********************
    // Checks
    // ********************
    deep_no_char_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
        state_ff == LPW_DEEP && rx_char_pulse && !trig_rise && !abort_cmd && !clk_hit
            && !(sec_tick && left_ff == {{(SECS_W-1){1'b0}}, 1'b1}) |=> state_ff == LPW_DEEP)
        else $error("character ended deep sleep");
    deep_trig_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
        state_ff == LPW_DEEP && trig_rise && !abort_cmd |=> state_ff == LPW_ACTIVE && src_ff == `LPW_SRC_TRIG)
        else $error("trigger did not end deep sleep");
    deep_ports_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
        state_ff == LPW_DEEP |-> !led_en && !rs232_en && !usb_en && !logic_serial_en && !other_serial_en)
        else $error("port left on in deep sleep");
    light_leds_only_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
        state_ff == LPW_LIGHT |-> !led_en && rs232_en && usb_en && logic_serial_en)
        else $error("wrong functions off in light sleep");
    idle_keeps_char_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
        state_ff == LPW_LIGHT && is_idle_ff |=> !rx_char_drop)
        else $error("idle dropped waking character");
    sleep_drops_char_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
        state_ff == LPW_LIGHT && !is_idle_ff && ser_en_ff && rx_char_pulse && !trig_rise && !abort_cmd
            |=> rx_char_drop && src_ff == `LPW_SRC_CHAR)
        else $error("sleep kept waking character");
    secs_expire_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
        state_ff != LPW_ACTIVE && kind_ff == `LPW_KIND_SECS && sec_tick
            && left_ff == {{(SECS_W-1){1'b0}}, 1'b1} |=> state_ff == LPW_ACTIVE)
        else $error("timeout missed");
    bare_cmd_serial_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
        go_cmd && state_ff == LPW_ACTIVE && pwdata[`LPW_CTRL_NOARG_BIT] && cmd_mode == `LPW_MODE_SLEEP
            |=> ser_en_ff && kind_ff == `LPW_KIND_NONE)
        else $error("bare sleep not armed for character");
endmodule
`default_nettype wire

// >>> lpw_host.sv
// Host model: issues power commands to lpw_ctrl as an APB master.
// Assumes pclk is shared with the controller and pready may come late.
`timescale 1ns/1ps
`default_nettype none
`include "lpw_cfg.svh"
module lpw_host (
    // Clock
    input wire logic pclk,
    // APB master
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [11:0] paddr,
    output var logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic last_err;

    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        last_err = 1'h0;
    end

    // ****************
    // Bus cycles
    // ****************
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'h1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        xfer(1'h0, a, 32'h0, q);
    endtask

    // ****************
    // Power command
    // ****************
    // flag and argument
    task automatic cmd(input logic [1:0] m, input logic ser, input logic [2:0] k, input logic na,
                       input logic yr, input logic [31:0] secs, input logic [31:0] tt, input logic [31:0] td);
        wr(`LPW_SECS_OFF, secs);
        wr(`LPW_TGT_TIME_OFF, tt);
        wr(`LPW_TGT_DATE_OFF, td);
        wr(`LPW_CTRL_OFF, {22'h0, 1'h0, yr, na, k, ser, m, 1'h1});
    endtask
endmodule
`default_nettype wire

// >>> lpw_ctrl_tb.sv
// Self-checking bench for lpw_ctrl: entry into each low-power state and every wake source.
// Assumes lpw_host drives APB; the bench drives tick, clock fields, trigger and receive pulse.
`timescale 1ns/1ps
`default_nettype none
`include "lpw_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module lpw_ctrl_tb;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, s;
    logic sec_tick = 1'h0;
    logic [4:0] rtc_hour = 5'h0C;
    logic [5:0] rtc_min = 6'h22;
    logic [5:0] rtc_sec = 6'h38;
    logic [3:0] rtc_month = 4'h5;
    logic [4:0] rtc_day = 5'h05;
    logic [6:0] rtc_year = 7'h15;
    logic ext_trig_pin = 1'h0;
    logic rx_char_pulse = 1'h0;
    logic led_en, rs232_en, usb_en, logic_serial_en, other_serial_en, rx_char_drop, low_power;
    int n_errors = 0;
    int samples_checked = 0;
    int n_drop = 0;
    int d0;

    lpw_ctrl lpw_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sec_tick(sec_tick), .rtc_hour(rtc_hour), .rtc_min(rtc_min), .rtc_sec(rtc_sec),
        .rtc_month(rtc_month), .rtc_day(rtc_day), .rtc_year(rtc_year), .ext_trig_pin(ext_trig_pin),
        .rx_char_pulse(rx_char_pulse), .led_en(led_en), .rs232_en(rs232_en), .usb_en(usb_en),
        .logic_serial_en(logic_serial_en), .other_serial_en(other_serial_en),
        .rx_char_drop(rx_char_drop), .low_power(low_power));
    lpw_host lpw_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #20 pclk = ~pclk;
    always @(posedge pclk) if (rx_char_drop === 1'h1) n_drop++;

    // ****************
    // Helpers
    // ****************
    task automatic clk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic enter(input logic [1:0] m, input logic ser, input logic [2:0] k, input logic na,
                         input logic yr, input logic [31:0] secs, input logic [31:0] tt, input logic [31:0] td);
        lpw_host_i.cmd(m, ser, k, na, yr, secs, tt, td);
        clk(2);
        `CHK("low_power", 1'h1, low_power)
        `CHK("led_en", 1'h0, led_en)
        `CHK("serial_en", (m == `LPW_MODE_DEEP) ? 4'h0 : 4'hF,
            {rs232_en, usb_en, logic_serial_en, other_serial_en})
    endtask

    task automatic tick(input logic [4:0] h, input logic [5:0] mi, sc, input logic [3:0] mo,
                        input logic [4:0] d, input logic [6:0] y);
        @(posedge pclk);
        {rtc_hour, rtc_min, rtc_sec, rtc_month, rtc_day, rtc_year} <= {h, mi, sc, mo, d, y};
        clk(2);
        sec_tick <= 1'h1;
        @(posedge pclk);
        sec_tick <= 1'h0;
        clk(3);
    endtask

    task automatic chr();
        @(posedge pclk);
        rx_char_pulse <= 1'h1;
        @(posedge pclk);
        rx_char_pulse <= 1'h0;
        clk(3);
    endtask

    task automatic stay();
        clk(2);
        `CHK("still_low", 1'h1, low_power)
    endtask

    task automatic woke(input logic [2:0] src);
        int i;
        for (i = 0; i < 20 && low_power !== 1'h0; i++) @(posedge pclk);
        lpw_host_i.rd(`LPW_STAT_OFF, s);
        `CHK("status", {src, 2'h0}, s[4:0])
        `CHK("enables", 5'h1F, {led_en, rs232_en, usb_en, logic_serial_en, other_serial_en})
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        lpw_host_i.rd(`LPW_STAT_OFF, s);
        `CHK("status_rst", 32'h0, s)
        lpw_host_i.rd(12'h01C, s);
        `CHK("pslverr", 1'h1, lpw_host_i.last_err)
    endtask

    task automatic t_sleep_noarg();
        d0 = n_drop;
        enter(`LPW_MODE_SLEEP, 1'h0, `LPW_KIND_NONE, 1'h1, 1'h0, 32'h0, 32'h0, 32'h0);
        tick(5'h0C, 6'h22, 6'h39, 4'h5, 5'h05, 7'h15);
        stay();
        chr();
        woke(`LPW_SRC_CHAR);
        `CHK("drop_sleep", d0 + 1, n_drop)
    endtask

    task automatic t_idle_char();
        d0 = n_drop;
        enter(`LPW_MODE_IDLE, 1'h1, `LPW_KIND_NONE, 1'h0, 1'h0, 32'h0, 32'h0, 32'h0);
        chr();
        woke(`LPW_SRC_CHAR);
        `CHK("drop_idle", d0, n_drop)
    endtask

    task automatic t_sleep_secs();
        enter(`LPW_MODE_SLEEP, 1'h0, `LPW_KIND_SECS, 1'h0, 1'h0, 32'h2, 32'h0, 32'h0);
        chr();
        tick(5'h0C, 6'h22, 6'h3A, 4'h5, 5'h05, 7'h15);
        stay();
        tick(5'h0C, 6'h22, 6'h3B, 4'h5, 5'h05, 7'h15);
        woke(`LPW_SRC_SECS);
    endtask

    task automatic t_sleep_both();
        enter(`LPW_MODE_SLEEP, 1'h1, `LPW_KIND_SECS, 1'h0, 1'h0, 32'h3C, 32'h0, 32'h0);
        tick(5'h0C, 6'h23, 6'h00, 4'h5, 5'h05, 7'h15);
        chr();
        woke(`LPW_SRC_CHAR);
    endtask

    task automatic t_sleep_time();
        enter(`LPW_MODE_SLEEP, 1'h0, `LPW_KIND_TIME, 1'h0, 1'h0, 32'h0, 32'h0010_0000, 32'h0);
        chr();
        tick(5'h0F, 6'h3B, 6'h3B, 4'h5, 5'h05, 7'h15);
        stay();
        tick(5'h10, 6'h00, 6'h00, 4'h5, 5'h05, 7'h15);
        woke(`LPW_SRC_CLOCK);
    endtask

    task automatic t_sleep_top();
        enter(`LPW_MODE_SLEEP, 1'h0, `LPW_KIND_TOP, 1'h0, 1'h0, 32'h0, 32'h0, 32'h0);
        chr();
        tick(5'h0C, 6'h22, 6'h00, 4'h5, 5'h05, 7'h15);
        stay();
        tick(5'h0D, 6'h00, 6'h00, 4'h5, 5'h05, 7'h15);
        woke(`LPW_SRC_CLOCK);
    endtask

    task automatic t_deep_secs();
        enter(`LPW_MODE_DEEP, 1'h1, `LPW_KIND_SECS, 1'h0, 1'h0, 32'h2, 32'h0, 32'h0);
        tick(5'h0C, 6'h22, 6'h38, 4'h5, 5'h05, 7'h15);
        chr();
        stay();
        tick(5'h0C, 6'h22, 6'h39, 4'h5, 5'h05, 7'h15);
        woke(`LPW_SRC_SECS);
    endtask

    task automatic t_deep_trig();
        enter(`LPW_MODE_DEEP, 1'h0, `LPW_KIND_TIME, 1'h0, 1'h0, 32'h0, 32'h0017_3B3B, 32'h0);
        @(posedge pclk);
        ext_trig_pin <= 1'h1;
        woke(`LPW_SRC_TRIG);
        ext_trig_pin <= 1'h0;
    endtask

    task automatic t_deep_date();
        enter(`LPW_MODE_DEEP, 1'h0, `LPW_KIND_DATE, 1'h0, 1'h0, 32'h0, 32'h0, 32'h0000_0A16);
        tick(5'h01, 6'h00, 6'h00, 4'hA, 5'h16, 7'h15);
        stay();
        tick(5'h00, 6'h00, 6'h00, 4'hA, 5'h16, 7'h15);
        woke(`LPW_SRC_CLOCK);
    endtask

    task automatic t_deep_year();
        enter(`LPW_MODE_DEEP, 1'h0, `LPW_KIND_DATE, 1'h0, 1'h1, 32'h0, 32'h0, 32'h0016_0A16);
        tick(5'h00, 6'h00, 6'h00, 4'hA, 5'h16, 7'h15);
        stay();
        tick(5'h00, 6'h00, 6'h00, 4'hA, 5'h16, 7'h16);
        woke(`LPW_SRC_CLOCK);
    endtask

    task automatic t_deep_dttm();
        enter(`LPW_MODE_DEEP, 1'h0, `LPW_KIND_DTTM, 1'h0, 1'h0, 32'h0, 32'h0001_0000, 32'h0000_0A16);
        tick(5'h01, 6'h00, 6'h00, 4'hA, 5'h15, 7'h15);
        stay();
        tick(5'h01, 6'h00, 6'h00, 4'hA, 5'h16, 7'h15);
        woke(`LPW_SRC_CLOCK);
    endtask

    task automatic t_abort();
        enter(`LPW_MODE_IDLE, 1'h0, `LPW_KIND_NONE, 1'h0, 1'h0, 32'h0, 32'h0, 32'h0);
        stay();
        lpw_host_i.wr(`LPW_CTRL_OFF, 32'h1 << `LPW_CTRL_ABORT_BIT);
        woke(`LPW_SRC_ABORT);
    endtask

    // ****************
    // Run control
    // ****************
    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk(4);
        presetn <= 1'h1;
        t_reset();
        t_sleep_noarg();
        t_idle_char();
        t_sleep_secs();
        t_sleep_both();
        t_sleep_time();
        t_sleep_top();
        t_deep_secs();
        t_deep_trig();
        t_deep_date();
        t_deep_year();
        t_deep_dttm();
        t_abort();
        end_of_test();
    end

    initial begin
        #(40 * 20000);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
